/* lpsc_pkg.sv */
package lpsc_pkg;

    // Power states of the controller.
    typedef enum logic [2:0] {
        LPSC_RUN       = 3'b000,
        LPSC_SG_ACK    = 3'b001,
        LPSC_STOPGNT   = 3'b010,
        LPSC_SLEEP     = 3'b011,
        LPSC_RESUME    = 3'b100,
        LPSC_MGMT_SAVE = 3'b101,
        LPSC_MGMT_ACK  = 3'b110,
        LPSC_MGMT_RUN  = 3'b111
    } lpsc_state_e;

    // Acknowledge transaction codes on the bus request port.
    localparam logic [1:0] LPSC_ACK_NONE    = 2'h0;
    localparam logic [1:0] LPSC_ACK_STOPGNT = 2'h1;
    localparam logic [1:0] LPSC_ACK_MGMT    = 2'h2;

    // Default synchroniser depth and pending-interrupt width.
    localparam int LPSC_SYNC_STAGES = 2;
    localparam int LPSC_IRQ_W       = 8;

    // All-clear value of a pending-interrupt vector of the default width.
    localparam logic [LPSC_IRQ_W-1:0] LPSC_IRQ_ZERO = '0;

endpackage

/* lpsc_sync.sv */
`timescale 1ns/1ps
module lpsc_sync
    import lpsc_pkg::*;
#(
    parameter int STAGES = LPSC_SYNC_STAGES,
    parameter logic RST_VAL = 1'b1
) (
    // Clock and reset
    input  wire logic sys_clk_i,
    input  wire logic resetn_i,
    // Data
    input  wire logic async_i,
    output logic      sync_o
);
    logic [STAGES-1:0] chain_reg;
    logic [STAGES-1:0] chain_next;

    // A single stage would let a metastable value reach the state machine.
    if (STAGES < 2) begin : g_bad_stages
        $error("lpsc_sync needs at least two stages");
    end

    always_comb begin
        chain_next = {chain_reg[STAGES-2:0], async_i};
    end

    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            chain_reg <= {STAGES{RST_VAL}};
        end else begin
            chain_reg <= chain_next;
        end
    end

    assign sync_o = chain_reg[STAGES-1];

endmodule // lpsc_sync

/* lpsc_ctrl.sv */
// What this block does
// - Stop-clock request moves the core to Stop-Grant and issues a Stop-Grant acknowledge on the bus.
// - In Stop-Grant only the bus unit and interrupt controller clocks run.
// - In Stop-Grant bus snooping goes on and arriving interrupts are latched pending.
// - Removing the stop-clock request restarts all clocks, services pending interrupts, then resumes execution.
// - The stop-clock request may be asynchronous and never affects the bus clock.
// - Sleep request in Stop-Grant enters Sleep with all unit clocks off, only the PLL running.
// - In Sleep snoops, interrupts and stop-clock are ignored; only sleep and reset matter.
// - Removing the sleep request returns to Stop-Grant with bus and interrupt controller clocks restarted.
// - An accepted management interrupt saves state, enters management mode, acknowledges on the bus, runs the handler.
// - Reset forces a known state from any power state, Sleep included.
`timescale 1ns/1ps
module lpsc_ctrl
    import lpsc_pkg::*;
#(
    parameter int IRQ_W = LPSC_IRQ_W
) (
    // Clock and reset
    input  wire logic             sys_clk_i,
    input  wire logic             resetn_i,
    // Requests from system logic
    input  wire logic             stop_clock_request_n_i,
    input  wire logic             sleep_request_n_i,
    input  wire logic             sys_mgmt_interrupt_n_i,
    // Interrupt and snoop sources
    input  wire logic [IRQ_W-1:0] irq_i,
    input  wire logic             snoop_req_i,
    input  wire logic             mgmt_exit_i,
    input  wire logic             state_saved_i,
    input  wire logic             irq_serviced_i,
    input  wire logic             bus_ack_done_i,
    // Clock gating
    output logic                  pll_en_o,
    output logic                  core_clk_en_o,
    output logic                  bus_clk_en_o,
    output logic                  lic_clk_en_o,
    // Bus and core control
    output logic [1:0]            ack_cycle_o,
    output logic                  snoop_en_o,
    output logic [IRQ_W-1:0]      irq_pending_o,
    output logic                  save_state_o,
    output logic                  firmware_mgmt_mode_o,
    output logic                  exec_en_o
);
    if (IRQ_W < 1) begin : g_bad_irq_w
        $error("IRQ_W must be at least one");
    end

    ////////////////////////////////////////////////////////////////////////////////
    logic stop_n_s;
    logic sleep_n_s;
    logic mgmt_irq_n_s;

    lpsc_sync #(.STAGES(LPSC_SYNC_STAGES), .RST_VAL(1'b1)) u_sync_stp (
        .sys_clk_i (sys_clk_i),
        .resetn_i  (resetn_i),
        .async_i   (stop_clock_request_n_i),
        .sync_o    (stop_n_s)
    );
    lpsc_sync #(.STAGES(LPSC_SYNC_STAGES), .RST_VAL(1'b1)) u_sync_slp (
        .sys_clk_i (sys_clk_i),
        .resetn_i  (resetn_i),
        .async_i   (sleep_request_n_i),
        .sync_o    (sleep_n_s)
    );
    lpsc_sync #(.STAGES(LPSC_SYNC_STAGES), .RST_VAL(1'b1)) u_sync_smi (
        .sys_clk_i (sys_clk_i),
        .resetn_i  (resetn_i),
        .async_i   (sys_mgmt_interrupt_n_i),
        .sync_o    (mgmt_irq_n_s)
    );

    ////////////////////////////////////////////////////////////////////////////////
    lpsc_state_e      state_reg,   state_next;
    logic [IRQ_W-1:0] pend_reg,    pend_next;
    logic             mgmt_reg,    mgmt_next;
    logic [1:0]       ack_reg,     ack_next;
    logic             pll_reg,     pll_next;
    logic             core_reg,    core_next;
    logic             bus_reg,     bus_next;
    logic             lic_reg,     lic_next;
    logic             snoop_reg,   snoop_next;
    logic             save_reg,    save_next;
    logic             exec_reg,    exec_next;

    always_comb begin
        state_next = state_reg;
        pend_next  = pend_reg;
        mgmt_next  = mgmt_reg;
        ack_next   = LPSC_ACK_NONE;
        case (state_reg)
            LPSC_RUN: begin
                if (!mgmt_irq_n_s && !mgmt_reg) begin
                    state_next = LPSC_MGMT_SAVE;
                end else if (!stop_n_s) begin
                    state_next = LPSC_SG_ACK;
                end
            end
            LPSC_SG_ACK: begin
                ack_next = LPSC_ACK_STOPGNT;
                if (bus_ack_done_i) begin
                    ack_next   = LPSC_ACK_NONE;
                    state_next = LPSC_STOPGNT;
                end
            end
            LPSC_STOPGNT: begin
                pend_next = pend_reg | irq_i;
                if (stop_n_s) begin
                    state_next = LPSC_RESUME;
                end else if (!sleep_n_s) begin
                    state_next = LPSC_SLEEP;
                end
            end
            LPSC_SLEEP: begin
                if (sleep_n_s) begin
                    state_next = LPSC_STOPGNT;
                end
            end
            LPSC_RESUME: begin
                if (irq_serviced_i || pend_reg == '0) begin
                    pend_next  = '0;
                    // A stop taken inside the handler must return to it, or mode would stick.
                    state_next = mgmt_reg ? LPSC_MGMT_RUN : LPSC_RUN;
                end
            end
            LPSC_MGMT_SAVE: begin
                if (state_saved_i) begin
                    mgmt_next  = 1'b1;
                    state_next = LPSC_MGMT_ACK;
                end
            end
            LPSC_MGMT_ACK: begin
                ack_next = LPSC_ACK_MGMT;
                if (bus_ack_done_i) begin
                    ack_next   = LPSC_ACK_NONE;
                    state_next = LPSC_MGMT_RUN;
                end
            end
            LPSC_MGMT_RUN: begin
                // The handler runs as normal execution; exit returns to RUN.
                if (mgmt_exit_i) begin
                    mgmt_next  = 1'b0;
                    state_next = LPSC_RUN;
                end else if (!stop_n_s) begin
                    state_next = LPSC_SG_ACK;
                end
            end
            default: begin
                state_next = LPSC_RUN;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Outputs are registered from the next state so each leaves a flip-flop.
    always_comb begin
        pll_next   = 1'b1;
        bus_next   = 1'b1;
        lic_next   = 1'b1;
        core_next  = 1'b1;
        snoop_next = 1'b1;
        save_next  = 1'b0;
        exec_next  = 1'b0;
        case (state_next)
            LPSC_STOPGNT: begin
                core_next = 1'b0;
            end
            LPSC_SLEEP: begin
                core_next  = 1'b0;
                bus_next   = 1'b0;
                lic_next   = 1'b0;
                snoop_next = 1'b0;
            end
            LPSC_RUN, LPSC_MGMT_RUN: begin
                exec_next = 1'b1;
            end
            LPSC_MGMT_SAVE: begin
                save_next = 1'b1;
            end
            default: begin
                core_next = 1'b1;
            end
        endcase
    end

    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            state_reg <= LPSC_RUN;
            pend_reg  <= '0;
            mgmt_reg  <= 1'b0;
            ack_reg   <= LPSC_ACK_NONE;
            pll_reg   <= 1'b1;
            core_reg  <= 1'b1;
            bus_reg   <= 1'b1;
            lic_reg   <= 1'b1;
            snoop_reg <= 1'b1;
            save_reg  <= 1'b0;
            exec_reg  <= 1'b1;
        end else begin
            state_reg <= state_next;
            pend_reg  <= pend_next;
            mgmt_reg  <= mgmt_next;
            ack_reg   <= ack_next;
            pll_reg   <= pll_next;
            core_reg  <= core_next;
            bus_reg   <= bus_next;
            lic_reg   <= lic_next;
            snoop_reg <= snoop_next;
            save_reg  <= save_next;
            exec_reg  <= exec_next;
        end
    end

    assign pll_en_o             = pll_reg;
    assign core_clk_en_o        = core_reg;
    assign bus_clk_en_o         = bus_reg;
    assign lic_clk_en_o         = lic_reg;
    assign ack_cycle_o          = ack_reg;
    assign snoop_en_o           = snoop_reg;
    assign irq_pending_o        = pend_reg;
    assign save_state_o         = save_reg;
    assign firmware_mgmt_mode_o = mgmt_reg;
    assign exec_en_o            = exec_reg;

    ////////////////////////////////////////////////////////////////////////////////
    sequence s_stp_seen;
        state_reg == LPSC_RUN && !stop_n_s && mgmt_irq_n_s;
    endsequence
    property p_stopgnt_ack;
        @(posedge sys_clk_i) disable iff (!resetn_i)
        s_stp_seen |=> ##1 (ack_cycle_o == LPSC_ACK_STOPGNT);
    endproperty
    a_stopgnt_ack: assert property (p_stopgnt_ack) else $error("no stop-grant ack");
    property p_sg_gating;
        @(posedge sys_clk_i) disable iff (!resetn_i)
        state_reg == LPSC_STOPGNT |-> !core_clk_en_o && bus_clk_en_o && lic_clk_en_o;
    endproperty
    a_sg_gating: assert property (p_sg_gating) else $error("stop-grant gating wrong");
    property p_latch_irq;
        @(posedge sys_clk_i) disable iff (!resetn_i)
        state_reg == LPSC_STOPGNT && irq_i[0] |=> irq_pending_o[0] && snoop_en_o;
    endproperty
    a_latch_irq: assert property (p_latch_irq) else $error("interrupt not latched");
    property p_resume;
        @(posedge sys_clk_i) disable iff (!resetn_i)
        state_reg == LPSC_RESUME && (pend_reg == '0 || irq_serviced_i) |=> exec_en_o && core_clk_en_o;
    endproperty
    a_resume: assert property (p_resume) else $error("no resume");
    property p_sleep_clk;
        @(posedge sys_clk_i) disable iff (!resetn_i)
        state_reg == LPSC_SLEEP |-> pll_en_o && !bus_clk_en_o && !lic_clk_en_o && !core_clk_en_o;
    endproperty
    a_sleep_clk: assert property (p_sleep_clk) else $error("sleep clocks wrong");
    property p_sleep_quiet;
        @(posedge sys_clk_i) disable iff (!resetn_i)
        state_reg == LPSC_SLEEP |-> !snoop_en_o ##1 $stable(irq_pending_o);
    endproperty
    a_sleep_quiet: assert property (p_sleep_quiet) else $error("sleep not quiet");
    property p_sleep_exit;
        @(posedge sys_clk_i) disable iff (!resetn_i)
        state_reg == LPSC_SLEEP && sleep_n_s |=> bus_clk_en_o && lic_clk_en_o && !core_clk_en_o;
    endproperty
    a_sleep_exit: assert property (p_sleep_exit) else $error("sleep exit wrong");
    property p_mgmt_ack;
        @(posedge sys_clk_i) disable iff (!resetn_i)
        state_reg == LPSC_MGMT_SAVE && state_saved_i |=> firmware_mgmt_mode_o ##1 (ack_cycle_o == LPSC_ACK_MGMT);
    endproperty
    a_mgmt_ack: assert property (p_mgmt_ack) else $error("management ack missing");
    property p_reset;
        @(posedge sys_clk_i)
        !resetn_i |=> state_reg == LPSC_RUN && pll_en_o && !firmware_mgmt_mode_o;
    endproperty
    a_reset: assert property (p_reset) else $error("reset state wrong");
    property p_run_no_sleep;
        @(posedge sys_clk_i) disable iff (!resetn_i)
        state_reg == LPSC_RUN |=> state_reg != LPSC_SLEEP;
    endproperty
    a_run_no_sleep: assert property (p_run_no_sleep) else $error("sleep from run");

endmodule // lpsc_ctrl

/* lpsc_chipset.sv */
`timescale 1ns/1ps
module lpsc_chipset
    import lpsc_pkg::*;
(
    // Clock
    input  wire logic       sys_clk_i,
    // Acknowledge transactions seen on the bus
    input  wire logic [1:0] ack_cycle_i,
    input  wire logic [3:0] ack_delay_i,
    output logic            bus_ack_done_o,
    output logic [1:0]      last_ack_o
);
    logic [3:0] wait_cnt;

    initial begin
        bus_ack_done_o = 1'b0;
        wait_cnt       = 4'h0;
        last_ack_o     = LPSC_ACK_NONE;
    end

    ////////////////////////////////////////////////////////////////////////////
    // A slow chipset lets the acknowledge stand for several cycles before taking it.
    // take acknowledge
    always @(negedge sys_clk_i) begin
        bus_ack_done_o <= 1'b0;
        if (ack_cycle_i !== LPSC_ACK_NONE && !bus_ack_done_o) begin
            if (wait_cnt >= ack_delay_i) begin
                bus_ack_done_o <= 1'b1;
                last_ack_o     <= ack_cycle_i;
                wait_cnt       <= 4'h0;
            end else begin
                wait_cnt <= wait_cnt + 4'h1;
            end
        end else begin
            wait_cnt <= 4'h0;
        end
    end
endmodule // lpsc_chipset

/* tb_top.sv */
`timescale 1ns/1ps
module tb_top;
    import lpsc_pkg::*;
    logic       sys_clk_i, resetn_i, stop_n, sleep_n, mgmt_n;
    logic       mgmt_exit, saved, serviced, ack_done;
    logic       pll_en, core_en, bus_en, lic_en, snoop_en, save_st, mode, exec_en;
    logic [7:0] irq, pend;
    logic [3:0] ack_delay;
    logic [1:0] ack_cyc, last_ack;
    int         num_errors = 0;
    int         check_count = 0;

    lpsc_ctrl dut (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .stop_clock_request_n_i(stop_n),
        .sleep_request_n_i(sleep_n), .sys_mgmt_interrupt_n_i(mgmt_n), .irq_i(irq), .snoop_req_i(1'b0),
        .mgmt_exit_i(mgmt_exit), .state_saved_i(saved), .irq_serviced_i(serviced), .bus_ack_done_i(ack_done),
        .pll_en_o(pll_en), .core_clk_en_o(core_en), .bus_clk_en_o(bus_en), .lic_clk_en_o(lic_en),
        .ack_cycle_o(ack_cyc), .snoop_en_o(snoop_en), .irq_pending_o(pend), .save_state_o(save_st),
        .firmware_mgmt_mode_o(mode), .exec_en_o(exec_en));
    lpsc_chipset chipset (.sys_clk_i(sys_clk_i), .ack_cycle_i(ack_cyc), .ack_delay_i(ack_delay),
        .bus_ack_done_o(ack_done), .last_ack_o(last_ack));

    ////////////////////////////////////////////////////////////////////////////
    // Wide enough for every packed group compared below, so no bit is cut off.
    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected at %0t: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge sys_clk_i);
    endtask
    task automatic final_report();
        $display("mismatches %0d comparisons %0d", num_errors, check_count);
        if (num_errors == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        check({pll_en, core_en, bus_en, lic_en}, 4'hF, "clocks after reset");
        check({snoop_en, exec_en, mode, save_st}, 4'hC, "flags after reset");
        check({ack_cyc, pend}, 10'h000, "ack and pending after reset");
    endtask
    task automatic t_sleep_run();
        sleep_n = 1'b0;
        cyc(6);
        check({pll_en, core_en, bus_en, lic_en, exec_en}, 5'h1F, "sleep taken while running");
        sleep_n = 1'b1;
        cyc(3);
    endtask
    task automatic t_stop_grant(input logic [3:0] dly);
        ack_delay = dly;
        stop_n = 1'b0;
        cyc(2);
        check(exec_en, 1'b1, "request acted on before synchronising");
        for (int i = 0; i < 20 && ack_cyc !== LPSC_ACK_STOPGNT; i++) cyc(1);
        check(ack_cyc, LPSC_ACK_STOPGNT, "stop grant ack");
        for (int i = 0; i < 30 && ack_cyc !== LPSC_ACK_NONE; i++) cyc(1);
        check(last_ack, LPSC_ACK_STOPGNT, "ack code taken by bus");
        check({pll_en, core_en, bus_en, lic_en}, 4'hB, "stop grant clocks");
        check({snoop_en, exec_en}, 2'h2, "snoop on, execution off");
    endtask
    task automatic t_sleep();
        irq = 8'hA5;
        cyc(1);
        irq = 8'h00;
        cyc(2);
        check(pend, 8'hA5, "interrupts latched in stop grant");
        sleep_n = 1'b0;
        cyc(5);
        check({pll_en, core_en, bus_en, lic_en}, 4'h8, "sleep clocks");
        check(snoop_en, 1'b0, "snoop in sleep");
        irq = 8'h5A;
        cyc(3);
        irq = 8'h00;
        check(pend, 8'hA5, "interrupt latched in sleep");
        sleep_n = 1'b1;
        cyc(5);
        check({pll_en, core_en, bus_en, lic_en, snoop_en}, 5'h17, "back in stop grant");
    endtask
    task automatic t_resume();
        stop_n = 1'b1;
        for (int i = 0; i < 20 && core_en !== 1'b1; i++) cyc(1);
        check({pll_en, core_en, bus_en, lic_en}, 4'hF, "clocks restarted");
        check({exec_en, pend}, 9'h0A5, "pending served before execution");
        serviced = 1'b1;
        cyc(1);
        serviced = 1'b0;
        for (int i = 0; i < 10 && exec_en !== 1'b1; i++) cyc(1);
        check({exec_en, pend}, 9'h100, "execution resumed");
    endtask
    task automatic t_mgmt();
        ack_delay = 4'h0;
        mgmt_n = 1'b0;
        for (int i = 0; i < 20 && save_st !== 1'b1; i++) cyc(1);
        check({save_st, mode}, 2'h2, "state save begun");
        mgmt_n = 1'b1;
        saved = 1'b1;
        cyc(1);
        saved = 1'b0;
        for (int i = 0; i < 20 && ack_cyc !== LPSC_ACK_MGMT; i++) cyc(1);
        check(ack_cyc, LPSC_ACK_MGMT, "management ack");
        for (int i = 0; i < 20 && exec_en !== 1'b1; i++) cyc(1);
        check({mode, exec_en, last_ack}, 4'hE, "handler running");
        mgmt_exit = 1'b1;
        cyc(1);
        mgmt_exit = 1'b0;
        cyc(3);
        check({mode, exec_en, ack_cyc}, 4'h4, "management mode left");
    endtask
    task automatic t_reset_sleep();
        t_stop_grant(4'h0);
        sleep_n = 1'b0;
        cyc(5);
        check({pll_en, core_en, bus_en, lic_en}, 4'h8, "asleep before reset");
        resetn_i = 1'b0;
        stop_n = 1'b1;
        sleep_n = 1'b1;
        cyc(2);
        resetn_i = 1'b1;
        cyc(1);
        t_reset();
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        sys_clk_i = 1'b0;
        forever #20 sys_clk_i = ~sys_clk_i;
    end
    initial begin
        #(40 * 3000);
        num_errors++;
        $display("unexpected at %0t: watchdog expired", $time);
        final_report();
    end
    initial begin
        resetn_i = 1'b0;
        stop_n = 1'b1;
        sleep_n = 1'b1;
        mgmt_n = 1'b1;
        irq = 8'h00;
        mgmt_exit = 1'b0;
        saved = 1'b0;
        serviced = 1'b0;
        ack_delay = 4'h3;
        cyc(8);
        resetn_i = 1'b1;
        cyc(1);
        t_reset();
        t_sleep_run();
        t_stop_grant(4'h3);
        t_sleep();
        t_resume();
        t_mgmt();
        t_reset_sleep();
        final_report();
    end
endmodule // tb_top
